// file: rtcib_pkg.sv
// shared constants and types for the rtc indexed register bank
// assumes one 20 mhz clock and a synchronous 32.768 khz oscillator tick
package rtcib_pkg;

  // i/o port decode: addr[7:3] with addr[2] low selects the rtc window, addr[1:0] the port
  localparam logic [4:0] IO_BASE_HI = 5'h0e;
  localparam logic [1:0] PORT_STD_INDEX = 2'h0;
  localparam logic [1:0] PORT_STD_TARGET = 2'h1;
  localparam logic [1:0] PORT_EXT_INDEX = 2'h2;
  localparam logic [1:0] PORT_EXT_TARGET = 2'h3;

  // standard bank indices
  localparam logic [6:0] IDX_SECONDS = 7'h00;
  localparam logic [6:0] IDX_MINUTES = 7'h02;
  localparam logic [6:0] IDX_HOURS = 7'h04;
  localparam logic [6:0] IDX_DAY_OF_WEEK = 7'h06;
  localparam logic [6:0] IDX_DAY_OF_MONTH = 7'h07;
  localparam logic [6:0] IDX_MONTH = 7'h08;
  localparam logic [6:0] IDX_YEAR = 7'h09;
  localparam logic [6:0] IDX_CFG_A = 7'h0a;
  localparam logic [6:0] IDX_CFG_B = 7'h0b;
  localparam logic [6:0] IDX_CFG_C = 7'h0c;
  localparam logic [6:0] IDX_CFG_D = 7'h0d;
  localparam logic [6:0] IDX_USER_FIRST = 7'h0e;
  localparam int TIME_BYTES = 10;

  // field positions
  localparam int A_UIP_BIT = 7;
  localparam int B_SET_BIT = 7;
  localparam int B_PIE_BIT = 6;
  localparam int B_UIE_BIT = 4;
  localparam int B_SQWE_BIT = 3;
  localparam int B_DM_BIT = 2;
  localparam int C_IRQF_BIT = 7;
  localparam int C_PF_BIT = 6;
  localparam logic [7:0] REG_D_VALUE = 8'h80;

  // divider chain select codes
  localparam logic [2:0] DV_NORMAL = 3'h2;
  localparam logic [2:0] DV_BYP5 = 3'h3;
  localparam logic [2:0] DV_BYP10 = 3'h4;
  localparam logic [2:0] DV_BYP15 = 3'h5;
  localparam logic [15:0] STEP_NORMAL = 16'h0001;
  localparam logic [15:0] STEP_BYP5 = 16'h0020;
  localparam logic [15:0] STEP_BYP10 = 16'h0400;
  localparam logic [15:0] STEP_BYP15 = 16'h8000;

  // rate select codes
  localparam logic [3:0] RS_OFF = 4'h0;
  localparam logic [3:0] RS_ALIAS1 = 4'h1;
  localparam logic [3:0] RS_ALIAS2 = 4'h2;
  localparam logic [3:0] RS_ALIAS1_AS = 4'h8;
  localparam logic [3:0] RS_ALIAS2_AS = 4'h9;
  localparam logic [3:0] RS_FIRST_TAP = 4'h3;
  localparam logic [3:0] RS_TAP_OFFSET = 4'h2;

  // update-pending lead time, counted in oscillator ticks (rounded up)
  localparam longint OSC_HZ = 32768;
  localparam longint UIP_LEAD_NS = 244000;
  localparam longint NS_PER_S = 1000000000;
  localparam longint UIP_LEAD_TICKS =
    (UIP_LEAD_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S;
  localparam logic [14:0] UIP_START = 15'(OSC_HZ - UIP_LEAD_TICKS);

  // calendar limits (binary)
  localparam logic [7:0] SEC_WRAP = 8'h3c;
  localparam logic [7:0] HOUR_WRAP = 8'h18;
  localparam logic [7:0] DOW_LAST = 8'h07;
  localparam logic [7:0] MONTH_LAST = 8'h0c;
  localparam logic [7:0] YEAR_LAST = 8'h63;
  localparam logic [7:0] FEBRUARY = 8'h02;

  // host i/o request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcib_io_req_s;

  // divider chain state
  typedef struct packed {
    logic [14:0] cnt;
  } rtcib_div_s;

  // bank state
  typedef struct packed {
    logic [7:0] std_index;
    logic [7:0] ext_index;
    logic [TIME_BYTES-1:0][7:0] time_b;
    logic [6:0] cfg_a;
    logic [7:0] cfg_b;
    logic pf;
    logic irqf;
    logic [7:0] rdata;
    logic irq;
  } rtcib_bank_s;

endpackage

// file: rtcib_divider.sv
// oscillator divider chain with periodic tap select and update window
// assumes osc_tick is a one-clock pulse per 32.768 khz oscillator period
module rtcib_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // oscillator and configuration
  input wire logic osc_tick,
  input wire logic [2:0] divider_chain_select,
  input wire logic [3:0] periodic_rate_select,
  // events
  output logic sec_tick,
  output logic tap_tick,
  output logic uip_window
);
  import rtcib_pkg::*;

  rtcib_div_s q;
  rtcib_div_s d;
  logic [15:0] step;
  logic [15:0] sum;
  logic run;
  logic [3:0] eff;
  logic [3:0] k;

  // step per oscillator tick; reset and invalid codes hold the chain
  always_comb begin
    case (divider_chain_select)
      DV_NORMAL: step = STEP_NORMAL;
      DV_BYP5: step = STEP_BYP5;
      DV_BYP10: step = STEP_BYP10;
      DV_BYP15: step = STEP_BYP15;
      default: step = 16'h0000;
    endcase
    run = osc_tick && (step != 16'h0000);
    sum = {1'b0, q.cnt} + step;
    d = q;
    if (step == 16'h0000) begin
      d.cnt = 15'h0000; // 11x holds divider in reset
    end else if (run) begin
      d.cnt = sum[14:0];
    end
  end

  // tap selection: aliases, then falling edge of divider bit k
  always_comb begin
    case (periodic_rate_select)
      RS_ALIAS1: eff = RS_ALIAS1_AS;
      RS_ALIAS2: eff = RS_ALIAS2_AS;
      default: eff = periodic_rate_select;
    endcase
    k = eff - RS_TAP_OFFSET; // period doubles per code step
    tap_tick = run && (eff >= RS_FIRST_TAP) &&
      q.cnt[k] && !sum[k]; // code 0000 never fires
    sec_tick = run && sum[15];
    uip_window = (divider_chain_select == DV_NORMAL) &&
      (q.cnt >= UIP_START);
  end

  // chain register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// file: rtcib_bank.sv
// rtc indexed register bank: time bytes, config a-d, user and extended ram
// assumes host i/o cycles are one-clock strobes synchronous to clk

module rtcib_bank
  import rtcib_pkg::*;
(
  // clock and resume-well reset
  input wire logic clk,
  input wire logic rst_n,
  // oscillator tick
  input wire logic osc_tick,
  // host i/o port
  input wire rtcib_pkg::rtcib_io_req_s io_req,
  output logic [7:0] io_rdata,
  // periodic interrupt
  output logic periodic_irq
);

  rtcib_bank_s q;
  rtcib_bank_s d;
  logic [7:0] std_ram [0:127];
  logic [7:0] ext_ram [0:127];
  logic sec_tick;
  logic tap_tick;
  logic uip_window;
  logic hit;
  logic [6:0] sidx;
  logic [6:0] eidx;
  logic [7:0] s;
  logic [7:0] m;
  logic [7:0] h;
  logic [7:0] dw;
  logic [7:0] dm;
  logic [7:0] mo;
  logic [7:0] yr;
  logic dm_bin;
  logic std_wr;
  logic ext_wr;
  logic update_pending_flag;

  // bcd or binary byte to binary
  function automatic logic [7:0] to_bin(input logic [7:0] v,
                                        input logic bin);
    if (bin) begin
      return v;
    end
    return {4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]};
  endfunction

  // binary to bcd or binary byte
  function automatic logic [7:0] from_bin(input logic [7:0] v,
                                          input logic bin);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = v / 8'h0a;
    ones = v % 8'h0a;
    if (bin) begin
      return v;
    end
    return {tens[3:0], ones[3:0]};
  endfunction

  // days in a month, leap every fourth year
  function automatic logic [7:0] month_len(input logic [7:0] mon,
                                           input logic [7:0] year);
    case (mon)
      FEBRUARY: month_len = (year[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: month_len = 8'h1e;
      default: month_len = 8'h1f;
    endcase
  endfunction

  rtcib_divider u_div (
    .clk(clk),
    .rst_n(rst_n),
    .osc_tick(osc_tick),
    .divider_chain_select(q.cfg_a[6:4]),
    .periodic_rate_select(q.cfg_a[3:0]),
    .sec_tick(sec_tick),
    .tap_tick(tap_tick),
    .uip_window(uip_window)
  );

  // port decode and status
  always_comb begin
    hit = (io_req.addr[7:3] == IO_BASE_HI) && !io_req.addr[2];
    sidx = q.std_index[6:0];
    eidx = q.ext_index[6:0];
    dm_bin = q.cfg_b[B_DM_BIT];
    // flag reads zero while updates are inhibited
    update_pending_flag = uip_window && !q.cfg_b[B_SET_BIT];
    std_wr = io_req.wr && hit &&
      (io_req.addr[1:0] == PORT_STD_TARGET) &&
      (sidx >= IDX_USER_FIRST);
    ext_wr = io_req.wr && hit &&
      (io_req.addr[1:0] == PORT_EXT_TARGET);
  end

  // once-a-second calendar advance
  always_comb begin
    s = to_bin(q.time_b[IDX_SECONDS], dm_bin) + 8'h01;
    m = to_bin(q.time_b[IDX_MINUTES], dm_bin);
    h = to_bin(q.time_b[IDX_HOURS], dm_bin);
    dw = to_bin(q.time_b[IDX_DAY_OF_WEEK], dm_bin);
    dm = to_bin(q.time_b[IDX_DAY_OF_MONTH], dm_bin);
    mo = to_bin(q.time_b[IDX_MONTH], dm_bin);
    yr = to_bin(q.time_b[IDX_YEAR], dm_bin);
    if (s == SEC_WRAP) begin
      s = 8'h00;
      m = m + 8'h01;
      if (m == SEC_WRAP) begin
        m = 8'h00;
        h = h + 8'h01;
        if (h == HOUR_WRAP) begin
          h = 8'h00;
          dw = (dw >= DOW_LAST) ? 8'h01 : dw + 8'h01;
          dm = dm + 8'h01;
          if (dm > month_len(mo, yr)) begin
            dm = 8'h01;
            mo = mo + 8'h01;
            if (mo > MONTH_LAST) begin
              mo = 8'h01;
              yr = (yr >= YEAR_LAST) ? 8'h00 : yr + 8'h01;
            end
          end
        end
      end
    end
  end

  // next state: update cycle, host access, flags
  always_comb begin
    d = q;
    // one update per second unless inhibited
    if (sec_tick && !q.cfg_b[B_SET_BIT]) begin
      d.time_b[IDX_SECONDS] = from_bin(s, dm_bin);
      d.time_b[IDX_MINUTES] = from_bin(m, dm_bin);
      d.time_b[IDX_HOURS] = from_bin(h, dm_bin);
      d.time_b[IDX_DAY_OF_WEEK] = from_bin(dw, dm_bin);
      d.time_b[IDX_DAY_OF_MONTH] = from_bin(dm, dm_bin);
      d.time_b[IDX_MONTH] = from_bin(mo, dm_bin);
      d.time_b[IDX_YEAR] = from_bin(yr, dm_bin);
    end
    // host writes: index ports keep all eight bits
    if (io_req.wr && hit) begin
      case (io_req.addr[1:0])
        PORT_STD_INDEX: d.std_index = io_req.wdata;
        PORT_EXT_INDEX: d.ext_index = io_req.wdata;
        PORT_STD_TARGET: begin
          if (sidx < IDX_CFG_A) begin
            d.time_b[sidx] = io_req.wdata;
          end else if (sidx == IDX_CFG_A) begin
            d.cfg_a = io_req.wdata[6:0]; // bit 7 is status only
          end else if (sidx == IDX_CFG_B) begin
            d.cfg_b = io_req.wdata;
          end
        end
        default: d.cfg_b = d.cfg_b;
      endcase
    end
    // read data, register c clears its flags on read
    if (io_req.rd && hit) begin
      case (io_req.addr[1:0])
        PORT_STD_INDEX: d.rdata = q.std_index;
        PORT_EXT_INDEX: d.rdata = q.ext_index;
        PORT_STD_TARGET: begin
          if (sidx < IDX_CFG_A) begin
            d.rdata = q.time_b[sidx];
          end else if (sidx == IDX_CFG_A) begin
            d.rdata = {update_pending_flag, q.cfg_a};
          end else if (sidx == IDX_CFG_B) begin
            d.rdata = q.cfg_b;
          end else if (sidx == IDX_CFG_C) begin
            d.rdata = 8'h00;
            d.rdata[C_IRQF_BIT] = q.irqf;
            d.rdata[C_PF_BIT] = q.pf;
            d.pf = 1'b0;
            d.irqf = 1'b0;
          end else if (sidx == IDX_CFG_D) begin
            d.rdata = REG_D_VALUE;
          end else begin
            d.rdata = std_ram[sidx];
          end
        end
        default: d.rdata = ext_ram[eidx];
      endcase
    end
    // periodic tap: interrupt when enabled, else flag; set beats clear
    if (tap_tick) begin
      if (q.cfg_b[B_PIE_BIT]) begin
        d.irqf = 1'b1;
      end else begin
        d.pf = 1'b1;
      end
    end
    d.irq = d.irqf;
  end

  // state register; resume-well reset clears only its own bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.cfg_b[B_PIE_BIT] <= 1'b0;
      q.cfg_b[B_UIE_BIT] <= 1'b0;
      q.cfg_b[B_SQWE_BIT] <= 1'b0;
      q.pf <= 1'b0;
      q.irqf <= 1'b0;
      q.rdata <= 8'h00;
      q.irq <= 1'b0;
    end else begin
      q <= d; // cfg_a is never touched by reset
    end
  end

  // user and extended ram, no reset
  always_ff @(posedge clk) begin
    if (std_wr) begin
      std_ram[sidx] <= io_req.wdata;
    end
    if (ext_wr) begin
      ext_ram[eidx] <= io_req.wdata;
    end
  end

  assign io_rdata = q.rdata;
  assign periodic_irq = q.irq;

endmodule

// file: rtcib_bank_props.sv
// assertions on the rtc bank host port and periodic interrupt
// bound to rtcib_bank; sees only its ports
module rtcib_bank_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs
  input wire logic osc_tick,
  input wire rtcib_pkg::rtcib_io_req_s io_req,
  // outputs
  input wire logic [7:0] io_rdata,
  input wire logic periodic_irq
);
  import rtcib_pkg::*;
  logic win, rd_h, wr_i, wr_t, rd_t, rd_c, rs_zero;
  logic [7:0] idx;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // port decode of the standard pair
  assign win = io_req.addr[7:3] == IO_BASE_HI;
  assign rd_h = win && io_req.rd;
  assign wr_i = win && io_req.wr && io_req.addr[1:0] == PORT_STD_INDEX;
  assign wr_t = win && io_req.wr && io_req.addr[1:0] == PORT_STD_TARGET;
  assign rd_t = rd_h && io_req.addr[1:0] == PORT_STD_TARGET;
  assign rd_c = rd_t && idx[6:0] == IDX_CFG_C;
  // shadow index and zero-rate flag, tracked from host writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 8'h00;
      rs_zero <= 1'b0;
    end else begin
      if (wr_i) idx <= io_req.wdata;
      if (wr_t && idx[6:0] == IDX_CFG_A)
        rs_zero <= io_req.wdata[3:0] == RS_OFF;
    end
  end
  sequence s_ram_wr;
    wr_t && idx[6:0] >= IDX_USER_FIRST;
  endsequence
  sequence s_cfg_wr;
    wr_t && idx[6:0] == IDX_CFG_A;
  endsequence
  sequence s_rd_back;
    rd_t && !io_req.wr;
  endsequence
  a_rdata_hold: assert property (!rd_h |=> $stable(io_rdata))
    else $error("read data moved without a read");
  a_ram_echo: assert property (s_ram_wr ##2 s_rd_back |=>
    io_rdata == $past(io_req.wdata, 3)) else $error("user ram readback");
  a_cfg_echo: assert property (s_cfg_wr ##2 s_rd_back |=>
    (io_rdata & 8'h7f) == ($past(io_req.wdata, 3) & 8'h7f))
    else $error("config a readback");
  a_regd_value: assert property (rd_t && idx[6:0] == IDX_CFG_D |=>
    io_rdata == REG_D_VALUE) else $error("register d value");
  a_regc_low: assert property (rd_c |=> io_rdata[5:0] == 6'h00)
    else $error("register c low bits");
  a_irq_source: assert property ($rose(periodic_irq) |->
    $past(osc_tick)) else $error("irq without tap tick");
  a_irq_clear: assert property ($fell(periodic_irq) |-> $past(rd_c))
    else $error("irq dropped without flag read");
  a_rate_off: assert property ($rose(periodic_irq) |->
    !$past(rs_zero)) else $error("irq with rate off");
endmodule

bind rtcib_bank rtcib_bank_props i_props (.clk(clk), .rst_n(rst_n),
  .osc_tick(osc_tick), .io_req(io_req), .io_rdata(io_rdata),
  .periodic_irq(periodic_irq));

// file: rtcib_host.sv
// host software model: one i/o strobe at a time on the rtc ports
// assumes the bench clock; requests change on the falling edge
module rtcib_host (
  // clock
  input wire logic clk,
  // i/o port
  output rtcib_pkg::rtcib_io_req_s io_req,
  input wire logic [7:0] io_rdata
);
  import rtcib_pkg::*;
  initial io_req = '0;
  // one write strobe, address and data flipped once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    io_req <= '{1'b1, 1'b0, a, d};
    @(negedge clk);
    io_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // one read strobe, data taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    io_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    io_req <= '{1'b0, 1'b0, ~a, 8'hff};
    d = io_rdata;
  endtask
  // indexed access to the standard bank
  task automatic put(input logic [6:0] i, input logic [7:0] d);
    wr(8'h70, {1'b0, i});
    wr(8'h71, d);
  endtask
  task automatic get(input logic [6:0] i, output logic [7:0] d);
    wr(8'h70, {1'b0, i});
    rd(8'h71, d);
  endtask
endmodule

// file: rtcib_bank_bench.sv
// self-checking bench for the rtc indexed bank and rate select
// host model drives the i/o ports; bench drives osc_tick and reset
module rtcib_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rtcib_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic osc_tick = 1'b0;
  rtcib_io_req_s io_req;
  logic [7:0] io_rdata, d, e;
  logic periodic_irq;
  logic [6:0] x;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 63248;
  int i, k, t0, n;
  always #25 clk = ~clk;
  rtcib_bank i_dut (.clk(clk), .rst_n(rst_n), .osc_tick(osc_tick),
    .io_req(io_req), .io_rdata(io_rdata), .periodic_irq(periodic_irq));
  rtcib_host i_host (.clk(clk), .io_req(io_req), .io_rdata(io_rdata));
  // expected ticks between periodic events, 0 for none
  function automatic int period(input logic [3:0] rs);
    if (rs == RS_OFF) return 0;
    if (rs == RS_ALIAS1) return 128;
    if (rs == RS_ALIAS2) return 256;
    return 1 << (rs - 1);
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] x, string m);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic chk_n(input int g, input int x, input string m);
    check_count++;
    if (g != x) begin
      n_mismatch++;
      $display("ERROR %0t %s got %0d exp %0d", $time, m, g, x);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one oscillator tick
  task automatic tick();
    @(negedge clk);
    osc_tick = 1'b1;
    @(negedge clk);
    osc_tick = 1'b0;
  endtask
  // ticks between two periodic flags at rate rs, 0 if none
  task automatic measure(input logic [3:0] rs, output int got);
    int c;
    got = 0;
    c = -1;
    i_host.put(IDX_CFG_A, {4'h2, rs});
    i_host.get(IDX_CFG_C, d);
    for (int j = 0; j < 1100 && got == 0; j++) begin
      tick();
      i_host.rd(8'h71, d);
      if (c >= 0) c++;
      if (d[C_PF_BIT] === 1'b1) begin
        if (c > 0) got = c;
        c = 0;
      end
    end
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    i_host.put(IDX_CFG_B, 8'h04);
    i_host.put(IDX_CFG_A, 8'h70);
    // user ram and extended bank with random index and data
    for (i = 0; i < 24; i++) begin
      x = 7'($random(seed));
      if (x < IDX_USER_FIRST) x = x + IDX_USER_FIRST;
      if (i == 0) x = IDX_USER_FIRST;
      if (i == 1) x = 7'h7f;
      e = 8'($random(seed));
      i_host.put(x, e);
      i_host.rd(8'h71, d);
      chk(d, e, "ram echo");
      i_host.wr(8'h72, {1'b0, x});
      i_host.wr(8'h73, ~e);
      i_host.get(x, d);
      chk(d, e, "user ram");
      i_host.rd(8'h73, d);
      chk(d, ~e, "ext ram");
    end
    i_host.put(IDX_CFG_D, 8'h00);
    i_host.get(IDX_CFG_D, d);
    chk(d, REG_D_VALUE, "reg d");
    // config a survives reset, status bit not writable
    i_host.put(IDX_CFG_A, 8'hfb);
    i_host.rd(8'h71, d);
    chk(d, 8'h7b, "cfg a echo");
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    i_host.get(IDX_CFG_A, d);
    chk(d, 8'h7b, "cfg a kept");
    $display("bank tests done");
    // every rate code up to 1010, flag mode
    for (k = 0; k < 11; k++) begin
      measure(4'(k), n);
      chk_n(n, period(4'(k)), "rate");
    end
    $display("rate tests done");
    // interrupt instead of flag when enabled, cleared by register c read; enable cleared by reset
    i_host.put(IDX_CFG_B, 8'h44);
    i_host.put(IDX_CFG_A, 8'h23);
    i_host.get(IDX_CFG_C, d);
    repeat (6) tick();
    chk({7'h00, periodic_irq}, 8'h01, "irq");
    i_host.rd(8'h71, d);
    chk(d, 8'h80, "flags");
    @(negedge clk);
    chk({7'h00, periodic_irq}, 8'h00, "irq clear");
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    i_host.get(IDX_CFG_B, d);
    chk(d, 8'h04, "enable reset");
    $display("irq tests done");
    // update pending lead before the once-a-second update
    i_host.put(IDX_SECONDS, 8'h00);
    i_host.put(IDX_CFG_A, 8'h70);
    i_host.put(IDX_CFG_A, 8'h20);
    @(negedge clk);
    osc_tick = 1'b1;
    repeat (32700) @(negedge clk);
    osc_tick = 1'b0;
    t0 = 0;
    n = 0;
    for (i = 1; i <= 100 && n == 0; i++) begin
      tick();
      i_host.get(IDX_SECONDS, d);
      if (d !== 8'h00) n = i;
      else begin
        i_host.get(IDX_CFG_A, e);
        if (e[A_UIP_BIT] === 1'b0) t0 = i;
      end
    end
    if (n == 0) begin
      n_mismatch++;
      end_of_test();
    end
    chk(d, 8'h01, "second");
    chk_n(n - t0 >= 8, 1, "uip lead");
    $display("update test done");
    end_of_test();
  end
endmodule
